// File: rtl/hinge_safety_ctrl.sv
// Contract
// R1 - two guard inputs, two outputs switched together
// R2 - separate status output follows actuator detection
// R3 - outputs enable only with guard closed
// R4 - checks inputs and sensing redundancy itself
// R5 - either input drops: both outputs off
// R6 - re-arm needs both inputs off then on
// R7 - slow or partial opening turns outputs off
// R8 - re-arm needs full open then close
// R9 - actuator without inputs: status on, outputs off
// R10 - neither present: all off, power lamp green
// R11 - inputs disagree: flash input lamp, outputs off
// R12 - output fault: flash output lamp red, all off
// R13 - fundamental fault shows red lamp indication
// R14 - faults clear only by supply cycle
// R15 - chainable up to thirty-two units
// R16 - all good: outputs, status on, lamps green
// R17 - self test at power-up, power lamp orange
`timescale 1ns/1ps
module hinge_safety_ctrl
    import hinge_pkg::*;
#(
    parameter int unsigned SELF_TEST   = SELF_TEST_CYCLES,
    parameter int unsigned FLASH_HALF  = FLASH_HALF_CYCLES,
    parameter int unsigned DISAGREE    = DISAGREE_CYCLES,
    parameter int unsigned CHAIN_UNITS = MAX_CHAIN_UNITS
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic guard_in_a,
    input  wire logic guard_in_b,
    input  wire logic sense_a_closed,
    input  wire logic sense_b_closed,
    input  wire logic sense_a_open,
    input  wire logic sense_b_open,
    input  wire logic sense_limit,
    input  wire logic drive_fb_a,
    input  wire logic drive_fb_b,
    input  wire logic internal_fault,
    output logic      safety_switch_a,
    output logic      safety_switch_b,
    output logic      hinge_state_signal,
    output lamp_t     supply_lamp,
    output lamp_t     safety_drive_lamp,
    output lamp_t     guard_request_lamp,
    output lamp_t     hinge_sense_lamp
);
    localparam int unsigned STW = $clog2(SELF_TEST + 1);
    localparam int unsigned DGW = $clog2(DISAGREE + 1);

    if (SELF_TEST < 1 || DISAGREE < 1) begin : g_cnt_chk
        $error("counts must be at least one");
    end
    if (CHAIN_UNITS < 1 || CHAIN_UNITS > MAX_CHAIN_UNITS) begin : g_chain_chk
        $error("bad chain length"); // R15
    end

    typedef enum logic [2:0] {
        st_test,
        st_run,
        st_out_fault,
        st_int_fault
    } state_t;

    logic [1:0] rst_sync_r;
    wire        rst_q_b = rst_sync_r[1];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) rst_sync_r <= 2'b00;
        else rst_sync_r <= {rst_sync_r[0], 1'b1};
    end

    hinge_flash_if fl ();
    hinge_flash_div #(.HALF(FLASH_HALF)) u_flash (
        .clk   (clk),
        .rst_b (rst_q_b),
        .fl    (fl)
    );

    state_t         state_r;
    state_t         state_nxt;
    logic [STW-1:0] test_cnt_r;
    logic [DGW-1:0] dis_cnt_r;
    logic           in_lock_r;
    logic           act_lock_r;
    logic           was_open_r;
    logic           drive_r;

    // redundancy: both channels must agree before the actuator counts
    wire act_closed  = sense_a_closed & sense_b_closed;           // R3 R4
    wire act_open    = sense_a_open & sense_b_open;
    wire sense_clash = (sense_a_closed != sense_b_closed)
                     | (sense_a_closed & sense_a_open)
                     | (sense_b_closed & sense_b_open);           // R4
    wire both_in     = guard_in_a & guard_in_b;
    wire none_in     = ~guard_in_a & ~guard_in_b;
    wire in_differ   = guard_in_a ^ guard_in_b;
    wire irregular   = (dis_cnt_r == DGW'(DISAGREE));             // R11
    // an output whose readback differs from drive_r is a cross connection or short
    wire fb_bad      = (drive_fb_a != drive_r) | (drive_fb_b != drive_r); // R12
    wire test_done   = (test_cnt_r == STW'(SELF_TEST));
    wire run_st      = (state_r == st_run);
    wire partial     = run_st & sense_limit & ~act_open;          // R7
    wire enable_ok   = run_st & act_closed & both_in & ~in_lock_r
                     & ~act_lock_r & ~irregular & ~sense_limit;   // R3 R16
    // feedback checked one cycle after drive changes so switching edges pass
    logic drive_d_r;
    wire  out_fault  = run_st & (drive_r == drive_d_r) & fb_bad;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            st_test:      if (test_done) state_nxt = st_run;      // R17
            st_run: begin
                if (internal_fault || sense_clash) state_nxt = st_int_fault;
                else if (out_fault) state_nxt = st_out_fault;
            end
            // fault states only leave through reset, i.e. supply cycle
            st_out_fault: state_nxt = st_out_fault;               // R14
            st_int_fault: state_nxt = st_int_fault;               // R14
            default:      state_nxt = st_int_fault;
        endcase
    end

    always_ff @(posedge clk or negedge rst_q_b) begin
        if (!rst_q_b) begin
            state_r    <= st_test;
            test_cnt_r <= '0;
            dis_cnt_r  <= '0;
            drive_d_r  <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            test_cnt_r <= test_done ? test_cnt_r : test_cnt_r + 1'b1;
            drive_d_r  <= drive_r;
            if (!in_differ) dis_cnt_r <= '0;
            else if (!irregular) dis_cnt_r <= dis_cnt_r + 1'b1;
        end
    end

    // input dropout lock: set on input loss while driving or on irregular inputs, cleared by both off
    always_ff @(posedge clk or negedge rst_q_b) begin
        if (!rst_q_b) begin
            in_lock_r <= 1'b1;
        end else if (drive_r && !both_in) begin
            in_lock_r <= 1'b1;                                    // R5 R6
        end else if (irregular) begin
            in_lock_r <= 1'b1;                                    // R11
        end else if (none_in) begin
            in_lock_r <= 1'b0;                                    // R6
        end
    end

    // partial opening lock: cleared only after a full open then close
    always_ff @(posedge clk or negedge rst_q_b) begin
        if (!rst_q_b) begin
            act_lock_r <= 1'b0;
            was_open_r <= 1'b0;
        end else if (partial) begin
            act_lock_r <= 1'b1;                                   // R7
            was_open_r <= 1'b0;
        end else if (act_lock_r && act_open) begin
            was_open_r <= 1'b1;                                   // R8
        end else if (act_lock_r && was_open_r && act_closed) begin
            act_lock_r <= 1'b0;                                   // R8
            was_open_r <= 1'b0;
        end
    end

    wire hinge_nxt = (run_st & act_closed) | (run_st & sense_limit & ~both_in); // R2 R9

    lamp_t sup_nxt;
    lamp_t drv_nxt;
    lamp_t req_nxt;
    lamp_t sen_nxt;
    // flash phase toggles on each divider tick, so the drive, guard and sense lamps flash in step
    logic  flash_r;
    wire   flash_og = flash_r;

    always_ff @(posedge clk or negedge rst_q_b) begin
        if (!rst_q_b) begin
            flash_r <= 1'b0;
        end else if (fl.tick) begin
            flash_r <= ~flash_r;
        end
    end

    always_comb begin
        sup_nxt = lamp_off;
        drv_nxt = lamp_off;
        req_nxt = lamp_off;
        sen_nxt = lamp_off;
        case (state_r)
            st_test: sup_nxt = lamp_orange;                       // R17
            st_run: begin
                sup_nxt = lamp_green;                             // R10
                drv_nxt = enable_ok ? lamp_green : lamp_off;      // R16
                if (irregular) req_nxt = flash_og ? lamp_orange : lamp_green; // R11
                else if (both_in && !in_lock_r) req_nxt = lamp_green;
                if (sense_limit) sen_nxt = flash_og ? lamp_orange : lamp_green;
                else if (act_closed) sen_nxt = lamp_green;        // R9
            end
            st_out_fault: begin
                sup_nxt = lamp_green;
                drv_nxt = flash_og ? lamp_red : lamp_off;         // R12 R13
            end
            st_int_fault: sup_nxt = lamp_red;                     // R13
            default:      sup_nxt = lamp_red;
        endcase
    end

    always_ff @(posedge clk or negedge rst_q_b) begin
        if (!rst_q_b) begin
            drive_r            <= 1'b0;
            hinge_state_signal <= 1'b0;
            supply_lamp        <= lamp_off;
            safety_drive_lamp  <= lamp_off;
            guard_request_lamp <= lamp_off;
            hinge_sense_lamp   <= lamp_off;
        end else begin
            drive_r            <= enable_ok & state_nxt == st_run; // R1 R5 R12
            hinge_state_signal <= hinge_nxt & state_nxt == st_run; // R12
            supply_lamp        <= sup_nxt;
            safety_drive_lamp  <= drv_nxt;
            guard_request_lamp <= req_nxt;
            hinge_sense_lamp   <= sen_nxt;
        end
    end

    // both outputs come from one flop so they can never split
    assign safety_switch_a = drive_r;                             // R1
    assign safety_switch_b = drive_r;                             // R1
endmodule

// File: rtl/hinge_pkg.sv
package hinge_pkg;
    // lamp colour codes
    typedef enum logic [1:0] {
        lamp_off,
        lamp_green,
        lamp_orange,
        lamp_red
    } lamp_t;

    // self test length after supply-up, in ns, and derived cycles at 4 ns
    localparam int unsigned SELF_TEST_NS     = 40000;
    localparam int unsigned CLK_PERIOD_NS    = 4;
    localparam int unsigned SELF_TEST_CYCLES = SELF_TEST_NS / CLK_PERIOD_NS;
    // lamp flash half period in ns and cycles
    localparam int unsigned FLASH_HALF_NS     = 250000000;
    localparam int unsigned FLASH_HALF_CYCLES = FLASH_HALF_NS / CLK_PERIOD_NS;
    // largest chain length the unit supports
    localparam int unsigned MAX_CHAIN_UNITS = 32;
    // input disagreement tolerated before it counts as irregular, in cycles
    localparam int unsigned DISAGREE_CYCLES = 16;
endpackage

// File: rtl/hinge_flash_if.sv
`timescale 1ns/1ps
interface hinge_flash_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface

// File: rtl/hinge_flash_div.sv
`timescale 1ns/1ps
// divider giving a one-cycle tick at the end of each flash half period
module hinge_flash_div #(
    parameter int unsigned HALF = 1000
) (
    input  wire logic  clk,
    input  wire logic  rst_b,
    hinge_flash_if.src fl
);
    localparam int unsigned W = (HALF > 1) ? $clog2(HALF) : 1;

    if (HALF < 2) begin : g_half_chk
        $error("flash half period too short");
    end

    logic [W-1:0] cnt_r;
    logic         tick_r;
    wire          wrap = (cnt_r == W'(HALF - 1));

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= wrap ? '0 : cnt_r + 1'b1;
            tick_r <= wrap;
        end
    end

    assign fl.tick = tick_r;
endmodule

// File: sim/hinge_safety_ctrl_asserts.sv
`timescale 1ns/1ps
module hinge_safety_ctrl_asserts
    import hinge_pkg::*;
(
    input wire logic  clk,
    input wire logic  rst_b,
    input wire logic  guard_in_a,
    input wire logic  guard_in_b,
    input wire logic  sense_a_closed,
    input wire logic  sense_b_closed,
    input wire logic  sense_limit,
    input wire logic  safety_switch_a,
    input wire logic  safety_switch_b,
    input wire logic  hinge_state_signal,
    input wire lamp_t supply_lamp,
    input wire lamp_t safety_drive_lamp,
    input wire lamp_t guard_request_lamp,
    input wire lamp_t hinge_sense_lamp
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    property p_pair; safety_switch_a == safety_switch_b; endproperty
    a_pair: assert property (p_pair) else $error("switch pair split");
    property p_drop; !(guard_in_a && guard_in_b) |=> !safety_switch_a; endproperty
    a_drop: assert property (p_drop) else $error("switch on without both guards");
    property p_open; !sense_a_closed && !sense_b_closed |=> !safety_switch_a; endproperty
    a_open: assert property (p_open) else $error("switch on with guard open");
    property p_lamps; safety_switch_a |-> safety_drive_lamp == lamp_green
        && guard_request_lamp == lamp_green; endproperty
    a_lamps: assert property (p_lamps) else $error("run lamps not green");
    property p_idle; !guard_in_a && !guard_in_b && !sense_a_closed && !sense_b_closed
        && !sense_limit |=> !hinge_state_signal && hinge_sense_lamp == lamp_off; endproperty
    a_idle: assert property (p_idle) else $error("status on while idle");
    property p_test; supply_lamp == lamp_orange |-> !safety_switch_a
        && !hinge_state_signal; endproperty
    a_test: assert property (p_test) else $error("output during self test");
    property p_drv; safety_drive_lamp == lamp_red |-> !safety_switch_a
        && !hinge_state_signal; endproperty
    a_drv: assert property (p_drv) else $error("output during drive fault");
    property p_fault; supply_lamp == lamp_red |=> supply_lamp == lamp_red
        && !safety_switch_a; endproperty
    a_fault: assert property (p_fault) else $error("fault left without reset");
endmodule

bind hinge_safety_ctrl hinge_safety_ctrl_asserts chk (.clk(clk), .rst_b(rst_b),
    .guard_in_a(guard_in_a), .guard_in_b(guard_in_b), .sense_a_closed(sense_a_closed),
    .sense_b_closed(sense_b_closed), .sense_limit(sense_limit),
    .safety_switch_a(safety_switch_a), .safety_switch_b(safety_switch_b),
    .hinge_state_signal(hinge_state_signal), .supply_lamp(supply_lamp),
    .safety_drive_lamp(safety_drive_lamp), .guard_request_lamp(guard_request_lamp),
    .hinge_sense_lamp(hinge_sense_lamp));

// File: sim/hinge_pin_model.sv
`timescale 1ns/1ps
// output pin readback; a short flips channel b so it disagrees with its drive
module hinge_pin_model (
    input  wire logic safety_switch_a,
    input  wire logic safety_switch_b,
    input  wire logic short_on,
    output logic      drive_fb_a,
    output logic      drive_fb_b
);
    assign drive_fb_a = safety_switch_a;
    assign drive_fb_b = short_on ? !safety_switch_b : safety_switch_b;
endmodule

// File: sim/hinge_safety_ctrl_tb.sv
`timescale 1ns/1ps
module hinge_safety_ctrl_tb import hinge_pkg::*;;
    logic  clk = 0, rst_b = 0, ga = 0, gb = 0, sc = 0, so = 0, lim = 0, flt = 0, shrt = 0;
    logic  clash = 0;
    logic  sw_a, sw_b, hs, fb_a, fb_b, n_a, n_b;
    lamp_t lp_s, lp_d, lp_g, lp_h;
    int    miscompares = 0, checked = 0;
    initial forever #2 clk = ~clk;
    // short counts keep the run brief; sense b follows a except while clash is set
    hinge_safety_ctrl #(.SELF_TEST(8), .FLASH_HALF(4), .DISAGREE(3)) uut (
        .clk(clk), .rst_b(rst_b), .guard_in_a(ga), .guard_in_b(gb), .sense_a_closed(sc),
        .sense_b_closed(sc ^ clash), .sense_a_open(so), .sense_b_open(so), .sense_limit(lim),
        .drive_fb_a(fb_a), .drive_fb_b(fb_b), .internal_fault(flt), .safety_switch_a(sw_a),
        .safety_switch_b(sw_b), .hinge_state_signal(hs), .supply_lamp(lp_s),
        .safety_drive_lamp(lp_d), .guard_request_lamp(lp_g), .hinge_sense_lamp(lp_h));
    hinge_pin_model pins (.safety_switch_a(sw_a), .safety_switch_b(sw_b), .short_on(shrt),
        .drive_fb_a(fb_a), .drive_fb_b(fb_b));
    // second unit fed by the first, as in a series chain
    hinge_safety_ctrl #(.SELF_TEST(8), .FLASH_HALF(4), .DISAGREE(3)) next_unit (
        .clk(clk), .rst_b(rst_b), .guard_in_a(sw_a), .guard_in_b(sw_b), .sense_a_closed(sc),
        .sense_b_closed(sc), .sense_a_open(so), .sense_b_open(so), .sense_limit(lim),
        .drive_fb_a(n_a), .drive_fb_b(n_b), .internal_fault(flt), .safety_switch_a(n_a),
        .safety_switch_b(n_b), .hinge_state_signal(), .supply_lamp(), .safety_drive_lamp(),
        .guard_request_lamp(), .hinge_sense_lamp());
    task automatic end_sim;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [1:0] e, input logic [1:0] s);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value %s expected %0h seen %0h", n, e, s);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic put(input logic [4:0] v);
        {ga, gb, sc, so, lim} = v;
        step(2);
    endtask
    task automatic outs(input logic [1:0] sw, input logic h);
        chk("switch pair", sw, {sw_a, sw_b});
        chk("status", {1'b0, h}, {1'b0, hs});
    endtask
    // flashing lamp must show both colours within three half periods
    task automatic seen(input string n, input lamp_t c1, input lamp_t c2, ref lamp_t l);
        logic [1:0] m;
        m = 2'b00;
        repeat (12) begin
            step(1);
            m = m | {l === c2, l === c1};
        end
        chk(n, 2'b11, m);
    endtask
    task automatic reset;
        rst_b = 0;
        step(5);
        rst_b = 1;
        step(3);
        chk("self test lamp", lamp_orange, lp_s);
        outs(2'b00, 0);
        for (int i = 0; i < 40 && lp_s !== lamp_green; i++) step(1);
        chk("run lamp", lamp_green, lp_s);
        if (lp_s !== lamp_green) end_sim();
    endtask
    initial begin
        reset();
        put(5'b00100);
        outs(2'b00, 1);
        chk("guard lamp", lamp_off, lp_g);
        chk("drive lamp", lamp_off, lp_d);
        chk("sense lamp", lamp_green, lp_h);
        put(5'b11100);
        outs(2'b11, 1);
        chk("drive lamp", lamp_green, lp_d);
        chk("guard lamp", lamp_green, lp_g);
        chk("sense lamp", lamp_green, lp_h);
        chk("chain", 2'b11, {n_a, n_b});
        put(5'b01100);
        outs(2'b00, 1);
        chk("chain drop", 2'b00, {n_a, n_b});
        put(5'b11100);
        outs(2'b00, 1);
        put(5'b00100);
        put(5'b11100);
        outs(2'b11, 1);
        put(5'b11101);
        put(5'b11001);
        outs(2'b00, 0);
        put(5'b11100);
        chk("relock", 2'b00, {sw_a, sw_b});
        put(5'b11010);
        put(5'b11100);
        chk("rearm", 2'b11, {sw_a, sw_b});
        put(5'b00000);
        outs(2'b00, 0);
        chk("idle lamp", lamp_off, lp_g);
        chk("idle drive lamp", lamp_off, lp_d);
        chk("idle sense lamp", lamp_off, lp_h);
        chk("power lamp", lamp_green, lp_s);
        put(5'b10100);
        step(4);
        outs(2'b00, 1);
        seen("guard lamp flash", lamp_orange, lamp_green, lp_g);
        put(5'b00100);
        put(5'b11100);
        shrt = 1;
        step(2);
        outs(2'b00, 0);
        seen("drive lamp flash", lamp_red, lamp_off, lp_d);
        shrt = 0;
        put(5'b00100);
        put(5'b11100);
        outs(2'b00, 0);
        reset();
        put(5'b00100);
        put(5'b11100);
        outs(2'b11, 1);
        flt = 1;
        step(2);
        flt = 0;
        chk("fault lamp", lamp_red, lp_s);
        put(5'b00100);
        put(5'b11100);
        chk("fault hold", 2'b00, {sw_a, sw_b});
        reset();
        put(5'b00100);
        put(5'b11100);
        clash = 1;
        step(2);
        chk("clash lamp", lamp_red, lp_s);
        outs(2'b00, 0);
        end_sim();
    end
endmodule
